// file: hw/adcs_sequencer.sv
// adcs_sequencer: sar converter control with single and scan sequencing
// Functional notes
// - ten-bit successive approximation result; single and group scan modes
// - single mode starts converting selected channel when run bit becomes one
// - run bit stays one during single conversion, cleared at end, then idle
// - end flag set at conversion end; interrupt request when enabled
// - end flag cleared only by writing zero after reading it as one
// - each finished conversion stored in that channel's result register
// - scan starts at input 0 for group 0, input 4 for group 1
// - next scan channel starts right after previous finishes
// - scan keeps cycling while run bit is one; stops when cleared
// - scan sets end flag once per round, restarts at group first channel
// - restarting a stopped scan begins at the group's first channel
// - input sampled after a start delay that depends on write timing
// - speed zero: delay 10 to 17, sampling 64, total 259 to 266
// - speed one: delay 6 to 9, sampling 32, total 131 to 134
// - later scan conversions take exactly 256 or 128 states
// - timer trigger with trigger enable sets run bit and starts converter
// - triggered conversion behaves like a software start in both modes
// - inputs 0-3 to results a-d, inputs 4-6 to results a-c
// - channel field plus scan bit select inputs; code 111 reserved
// - upper byte read latches low byte into holding register
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
module adcs_sequencer
  import adcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_in,
  input wire logic timer_trigger,
  output logic sample_hold,
  output logic [RES_W-1:0] dac_code,
  output logic [2:0] active_channel,
  output logic end_irq_request
);
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] adcs_decode(input logic [ADDR_W-1:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a == OFF_CSR) s = SEL_CSR;
    if (a == OFF_TRG) s = SEL_TRG;
    if (a == OFF_LOW) s = SEL_LOW;
    if (a == OFF_RES_A) s = SEL_RES;
    if (a == OFF_RES_B) s = SEL_RES + 3'h1;
    if (a == OFF_RES_C) s = SEL_RES + 3'h2;
    if (a == OFF_RES_D) s = SEL_RES + 3'h3;
    return s;
  endfunction : adcs_decode

  // ----------------------------------------------------------------
  // bus handshake state
  // ----------------------------------------------------------------
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic awok_reg, awok_next, wok_reg, wok_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next, rdpend_reg, rdpend_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [2:0] rsel_reg, rsel_next, wsel, ar_sel;
  logic [31:0] rdata_reg, rdata_next;
  logic do_write;
  // converter and register state
  adcs_state_e state_reg, state_next;
  logic flag_reg, flag_next, fread_reg, fread_next;
  logic ie_reg, ie_next, run_reg, run_next, scan_reg, scan_next;
  logic spd_reg, spd_next, timer_trigger_enable_reg, timer_trigger_enable_next;
  logic [2:0] ch_reg, ch_next, chan_reg, chan_next;
  logic [7:0] hold_reg, hold_next, cnt_reg, cnt_next;
  logic [4:0] sub_reg, sub_next;
  logic [2:0] phase_reg;
  logic [RES_W-1:0] sar_reg, sar_next, trial_reg, trial_next;
  logic samp_reg, irq_reg, trig_d_reg;
  logic cmp_s1_reg, cmp_s2_reg;
  logic set_flag, eoc;
  logic mem_we;
  logic [RES_N-1:0] valid_reg, valid_next;
  logic [RES_W-1:0] mem_rd;
  logic [2:0] last_ch;

  // ----------------------------------------------------------------
  // axi4-lite slave: one write and one read at a time
  // ----------------------------------------------------------------
  always_comb
  begin
    awok_next = awok_reg | (s_axi_awvalid & awready_reg);
    wok_next = wok_reg | (s_axi_wvalid & wready_reg);
    awaddr_next = (s_axi_awvalid & awready_reg) ? s_axi_awaddr : awaddr_reg;
    wdata_next = (s_axi_wvalid & wready_reg) ? s_axi_wdata : wdata_reg;
    wstrb0_next = (s_axi_wvalid & wready_reg) ? s_axi_wstrb[0] : wstrb0_reg;
    wsel = adcs_decode(awaddr_reg);
    do_write = awok_reg & wok_reg & ~bvalid_reg;
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next = bresp_reg;
    if (do_write)
    begin
      awok_next = 1'b0;
      wok_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    awready_next = ~awok_next;
    wready_next = ~wok_next;
    // read: decode on address, data one cycle later from store
    rdpend_next = s_axi_arvalid & arready_reg;
    ar_sel = adcs_decode(s_axi_araddr);
    rsel_next = rdpend_next ? ar_sel : rsel_reg;
    arready_next = arready_reg ? ~rdpend_next : (rvalid_reg & s_axi_rready);
    rvalid_next = rdpend_reg | (rvalid_reg & ~s_axi_rready);
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rdpend_reg)
    begin
      rresp_next = (rsel_reg == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      rdata_next = 32'h0;
      if (rsel_reg == SEL_CSR)
        rdata_next[7:0] = {flag_reg, ie_reg, run_reg, scan_reg, spd_reg, ch_reg};
      if (rsel_reg == SEL_TRG)
        rdata_next[7:0] = {timer_trigger_enable_reg, TRG_RSV};
      if (rsel_reg == SEL_LOW)
        rdata_next[7:0] = hold_reg;
      if (rsel_reg[2])
        rdata_next[7:0] = valid_reg[rsel_reg[1:0]] ? mem_rd[RES_W-1:2] : 8'h00;
    end
  end

  // bus registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      awok_reg <= 1'b0;
      wok_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rdpend_reg <= 1'b0;
      rsel_reg <= SEL_NONE;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
    end
    else
    begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      awok_reg <= awok_next;
      wok_reg <= wok_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next | ~arready_reg & ~rvalid_reg & ~rdpend_reg;
      rdpend_reg <= rdpend_next;
      rsel_reg <= rsel_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer and control registers
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sub_next = sub_reg;
    sar_next = sar_reg;
    trial_next = trial_reg;
    chan_next = chan_reg;
    flag_next = flag_reg;
    fread_next = fread_reg;
    ie_next = ie_reg;
    run_next = run_reg;
    scan_next = scan_reg;
    spd_next = spd_reg;
    ch_next = ch_reg;
    timer_trigger_enable_next = timer_trigger_enable_reg;
    hold_next = hold_reg;
    set_flag = 1'b0;
    last_ch = {ch_reg[2], ch_reg[1:0]};
    eoc = (state_reg == ST_CONVERT) && (cnt_reg == 8'h0) && run_reg;
    mem_we = eoc;
    // slots never written read as zero, as after reset
    valid_next = valid_reg;
    if (mem_we)
      valid_next[chan_reg[1:0]] = 1'b1;
    if (state_reg != ST_IDLE && !run_reg)
      state_next = ST_IDLE;
    else
      unique case (state_reg)
        ST_IDLE:
          if (run_reg)
          begin
            state_next = ST_DELAY;
            cnt_next = spd_reg ? 8'(DLY1 - 1) + {6'h0, phase_reg[1:0] & 2'(JIT1)}
                               : 8'(DLY0 - 1) + {5'h0, phase_reg & 3'(JIT0)};
            chan_next = scan_reg ? {ch_reg[2], 2'b00} : ch_reg;
          end
        ST_DELAY:
          if (cnt_reg == 8'h0)
          begin
            state_next = ST_SAMPLE;
            cnt_next = spd_reg ? 8'(SPL1 - 1) : 8'(SPL0 - 1);
          end
          else
            cnt_next = cnt_reg - 8'h1;
        ST_SAMPLE:
          if (cnt_reg == 8'h0)
          begin
            state_next = ST_CONVERT;
            cnt_next = spd_reg ? 8'(CNV1 - 1) : 8'(CNV0 - 1);
            sub_next = spd_reg ? 5'(STEP1 - 1) : 5'(STEP0 - 1);
            trial_next = {1'b1, {(RES_W - 1){1'b0}}};
            sar_next = {1'b1, {(RES_W - 1){1'b0}}};
          end
          else
            cnt_next = cnt_reg - 8'h1;
        ST_CONVERT:
        begin
          cnt_next = cnt_reg - 8'h1;
          sub_next = sub_reg - 5'h1;
          if (sub_reg == 5'h0 && trial_reg != '0)
          begin
            // keep or drop the trial bit, then try the next one
            sub_next = spd_reg ? 5'(STEP1 - 1) : 5'(STEP0 - 1);
            trial_next = trial_reg >> 1;
            sar_next = (cmp_s2_reg ? sar_reg : (sar_reg & ~trial_reg)) | (trial_reg >> 1);
          end
          if (eoc && !scan_reg)
          begin
            state_next = ST_IDLE;
            run_next = 1'b0;
            set_flag = 1'b1;
          end
          else if (eoc)
          begin
            // back-to-back scan conversion with fixed short delay
            state_next = ST_DELAY;
            cnt_next = spd_reg ? 8'(SCD1 - 1) : 8'(SCD0 - 1);
            if (chan_reg == last_ch)
            begin
              set_flag = 1'b1;
              chan_next = {ch_reg[2], 2'b00};
            end
            else
              chan_next = chan_reg + 3'h1;
          end
        end
      endcase
    // software register writes (low byte lane only)
    if (do_write && wstrb0_reg && wsel == SEL_CSR)
    begin
      ie_next = wdata_reg[B_IE];
      run_next = wdata_reg[B_RUN];
      scan_next = wdata_reg[B_SCAN];
      spd_next = wdata_reg[B_SPD];
      ch_next = wdata_reg[2:0];
      if (!wdata_reg[B_FLAG] && fread_reg)
      begin
        flag_next = 1'b0;
        fread_next = 1'b0;
      end
    end
    if (do_write && wstrb0_reg && wsel == SEL_TRG)
      timer_trigger_enable_next = wdata_reg[B_TIMER_TRIGGER_ENABLE];
    // read side effects
    if (rdpend_reg && rsel_reg == SEL_CSR && flag_reg)
      fread_next = 1'b1;
    if (rdpend_reg && rsel_reg[2])
      hold_next = valid_reg[rsel_reg[1:0]] ? {mem_rd[1:0], 6'h00} : 8'h00;
    // timer trigger rising edge sets the run bit
    if (timer_trigger_enable_reg && timer_trigger && !trig_d_reg)
      run_next = 1'b1;
    if (set_flag)
      flag_next = 1'b1;
  end

  // sequencer registers; comparator passes two flops first
  always_ff @(posedge aclk)
  begin
    cmp_s1_reg <= comparator_in;
    cmp_s2_reg <= cmp_s1_reg;
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h0;
      sub_reg <= 5'h0;
      sar_reg <= '0;
      trial_reg <= '0;
      chan_reg <= CH_RST;
      valid_reg <= '0;
      flag_reg <= 1'b0;
      fread_reg <= 1'b0;
      ie_reg <= 1'b0;
      run_reg <= 1'b0;
      scan_reg <= 1'b0;
      spd_reg <= 1'b0;
      ch_reg <= CH_RST;
      timer_trigger_enable_reg <= 1'b0;
      hold_reg <= 8'h0;
      phase_reg <= 3'h0;
      samp_reg <= 1'b0;
      irq_reg <= 1'b0;
      trig_d_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sub_reg <= sub_next;
      sar_reg <= sar_next;
      trial_reg <= trial_next;
      chan_reg <= chan_next;
      valid_reg <= valid_next;
      flag_reg <= flag_next;
      fread_reg <= fread_next;
      ie_reg <= ie_next;
      run_reg <= run_next;
      scan_reg <= scan_next;
      spd_reg <= spd_next;
      ch_reg <= ch_next;
      timer_trigger_enable_reg <= timer_trigger_enable_next;
      hold_reg <= hold_next;
      phase_reg <= phase_reg + 3'h1;
      samp_reg <= (state_next == ST_SAMPLE);
      irq_reg <= flag_next & ie_next;
      trig_d_reg <= timer_trigger;
    end
  end

  // result store, indexed by input low bits
  adcs_result_mem #(.W(RES_W), .D(RES_N)) u_mem (
    .aclk(aclk),
    .we(mem_we),
    .wa(chan_reg[1:0]),
    .wd(sar_reg),
    .ra(ar_sel[1:0]),
    .rd(mem_rd)
  );

  // outputs straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign sample_hold = samp_reg;
  assign dac_code = sar_reg;
  assign active_channel = chan_reg;
  assign end_irq_request = irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  start_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_IDLE && run_reg |=> state_reg == ST_DELAY)
    else $error("run bit did not start a conversion");
  single_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    eoc && !scan_reg |=> !run_reg && state_reg == ST_IDLE && flag_reg)
    else $error("single end did not clear run and set flag");
  irq_raise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(flag_reg) && ie_reg |-> end_irq_request)
    else $error("end interrupt missing");
  flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(flag_reg) |-> $past(fread_reg))
    else $error("end flag cleared without prior read");
  scan_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_IDLE && run_reg && scan_reg |=> chan_reg == {ch_reg[2], 2'b00})
    else $error("scan did not start at first channel");
  abort_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg != ST_IDLE && !run_reg |=> state_reg == ST_IDLE && $stable(flag_reg))
    else $error("abort did not go idle");
  total_slow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(run_reg) && state_reg == ST_IDLE && !scan_reg && !spd_reg
    |-> ##[259:266] state_reg == ST_IDLE && !run_reg)
    else $error("slow single conversion time out of range");
  total_fast_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(run_reg) && state_reg == ST_IDLE && !scan_reg && spd_reg
    |-> ##[131:134] state_reg == ST_IDLE && !run_reg)
    else $error("fast single conversion time out of range");
  scan_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
    eoc && scan_reg && !spd_reg |-> ##256 (eoc || !run_reg || state_reg == ST_IDLE))
    else $error("scan conversion not 256 states");
  scan_fast_a: assert property (@(posedge aclk) disable iff (!aresetn)
    eoc && scan_reg && spd_reg |-> ##128 (eoc || !run_reg || state_reg == ST_IDLE))
    else $error("scan conversion not 128 states");
endmodule : adcs_sequencer

// file: hw/adcs_pkg.sv
// adcs_pkg: shared constants and types for the sequencer
package adcs_pkg;
  // ----------------------------------------------------------------
  // register map (byte offsets) and decode codes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CSR = 8'h00;
  localparam logic [7:0] OFF_TRG = 8'h04;
  localparam logic [7:0] OFF_RES_A = 8'h08;
  localparam logic [7:0] OFF_RES_B = 8'h0c;
  localparam logic [7:0] OFF_RES_C = 8'h10;
  localparam logic [7:0] OFF_RES_D = 8'h14;
  localparam logic [7:0] OFF_LOW = 8'h18;
  localparam logic [2:0] SEL_CSR = 3'h0;
  localparam logic [2:0] SEL_TRG = 3'h1;
  localparam logic [2:0] SEL_LOW = 3'h2;
  localparam logic [2:0] SEL_NONE = 3'h3;
  localparam logic [2:0] SEL_RES = 3'h4; // 4..7, low bits index
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int B_FLAG = 7;
  localparam int B_IE = 6;
  localparam int B_RUN = 5;
  localparam int B_SCAN = 4;
  localparam int B_SPD = 3;
  localparam int B_TIMER_TRIGGER_ENABLE = 7;
  localparam logic [6:0] TRG_RSV = 7'h7f;
  localparam logic [2:0] CH_RST = 3'h0;
  localparam int RES_W = 10;
  localparam int RES_N = 4;
  // ----------------------------------------------------------------
  // timing in states; one state is one aclk period (25 ns)
  // ----------------------------------------------------------------
  localparam int CYC_PER_STATE = 1;
  localparam int TD_MIN0 = 10;
  localparam int TD_MAX0 = 17;
  localparam int TD_MIN1 = 6;
  localparam int TD_MAX1 = 9;
  localparam int TSPL0 = 64;
  localparam int TSPL1 = 32;
  localparam int TOTAL_CONVERSION_TIME_MIN0 = 259;
  localparam int TOTAL_CONVERSION_TIME_MIN1 = 131;
  localparam int TSCAN0 = 256;
  localparam int TSCAN1 = 128;
  // delay phase cycles after the idle cycle that sees the run bit
  localparam int DLY0 = (TD_MIN0 - 1) * CYC_PER_STATE;
  localparam int DLY1 = (TD_MIN1 - 1) * CYC_PER_STATE;
  localparam int JIT0 = (TD_MAX0 - TD_MIN0) * CYC_PER_STATE;
  localparam int JIT1 = (TD_MAX1 - TD_MIN1) * CYC_PER_STATE;
  localparam int SPL0 = TSPL0 * CYC_PER_STATE;
  localparam int SPL1 = TSPL1 * CYC_PER_STATE;
  localparam int CNV0 = (TOTAL_CONVERSION_TIME_MIN0 - TD_MIN0 - TSPL0) * CYC_PER_STATE;
  localparam int CNV1 = (TOTAL_CONVERSION_TIME_MIN1 - TD_MIN1 - TSPL1) * CYC_PER_STATE;
  localparam int SCD0 = TSCAN0 * CYC_PER_STATE - SPL0 - CNV0;
  localparam int SCD1 = TSCAN1 * CYC_PER_STATE - SPL1 - CNV1;
  localparam int STEP0 = CNV0 / RES_W;
  localparam int STEP1 = CNV1 / RES_W;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_CONVERT = 2'b11
  } adcs_state_e;
endpackage : adcs_pkg

// file: hw/adcs_result_mem.sv
// adcs_result_mem: per-channel result store with registered read
module adcs_result_mem
  import adcs_pkg::*;
#(
  parameter int W = RES_W,
  parameter int D = RES_N
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [$clog2(D)-1:0] wa,
  input wire logic [W-1:0] wd,
  input wire logic [$clog2(D)-1:0] ra,
  output logic [W-1:0] rd
);
  logic [W-1:0] mem [D];

  // write port and registered read port
  always_ff @(posedge aclk)
  begin
    if (we)
    begin
      mem[wa] <= wd;
    end
    rd <= mem[ra];
  end
endmodule : adcs_result_mem

// file: sim/adcs_analog_model.sv
// adcs_analog_model: analog inputs seen through the sar comparator
module adcs_analog_model
  import adcs_pkg::*;
(
  input wire logic [RES_W-1:0] dac_code,
  input wire logic [2:0] active_channel,
  output logic comparator_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // fixed input levels, distinct per channel so a misrouted result shows
  localparam logic [RES_W-1:0] LV [8] = '{10'h2a5, 10'h0f3, 10'h37c, 10'h111, 10'h1c6, 10'h05a, 10'h3e9, 10'h000};
  // comparator high while the input is at or above the trial code
  assign comparator_in = (LV[active_channel] >= dac_code);
endmodule : adcs_analog_model

// file: sim/adcs_sequencer_bench.sv
// adcs_sequencer_bench: register-level tests of the converter sequencer
module adcs_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import adcs_pkg::*;
  localparam logic [9:0] LV [8] = '{10'h2a5, 10'h0f3, 10'h37c, 10'h111, 10'h1c6, 10'h05a, 10'h3e9, 10'h000};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rq;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cmp, trg = 1'b0, sh, irq;
  logic [1:0] bresp, rresp, rr;
  logic [9:0] dac;
  logic [2:0] ach;
  int error_cnt = 0, cmp_count = 0, cyc = 0, t0, t, t1, n, i;
  // ----------------------------------------------------------------
  // clock, design and analog source
  // ----------------------------------------------------------------
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  adcs_sequencer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comparator_in(cmp),
    .timer_trigger(trg), .sample_hold(sh), .dac_code(dac), .active_channel(ach), .end_irq_request(irq));
  adcs_analog_model src (.dac_code(dac), .active_channel(ach), .comparator_in(cmp));
  // ----------------------------------------------------------------
  // verdict, checks and bus tasks
  // ----------------------------------------------------------------
  task conclude;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  task tmo;
    error_cnt++;
    conclude();
  endtask : tmo
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", s, e, g);
      error_cnt++;
    end
  endtask : chk
  // write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      da = da | ha;
      dw = dw | hw;
      n++;
      if (n > 50) tmo();
    end
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      n++;
      if (n > 100) tmo();
    end
    while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  // read: address held until taken, data captured with rvalid
  task rd(input logic [7:0] a);
    logic ha;
    n = 0;
    ha = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      if (arvalid && arready) ha = 1'b1;
      rq = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      n++;
      if (n > 50) tmo();
    end
    while (!(rvalid === 1'b1 && ha));
    rready <= 1'b0;
  endtask : rd
  task rchk(input logic [7:0] a, input logic [31:0] e, input string s);
    rd(a);
    chk(s, e, rq);
  endtask : rchk
  // upper byte first, then the held low bits
  task res(input int slot, input int ch);
    rchk(OFF_RES_A + 8'(4 * slot), {24'h0, LV[ch][9:2]}, "res_hi");
    rchk(OFF_LOW, {24'h0, LV[ch][1:0], 6'h00}, "res_lo");
  endtask : res
  task wirq(output int tt);
    n = 0;
    while (irq !== 1'b1)
    begin
      @(negedge aclk);
      n++;
      if (n > 2000) tmo();
    end
    tt = cyc;
  endtask : wirq
  task pulse;
    @(posedge aclk);
    trg <= 1'b1;
    @(posedge aclk);
    trg <= 1'b0;
  endtask : pulse
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(OFF_CSR, 32'h00, "csr_reset");
    rchk(OFF_TRG, 32'h7f, "trg_reset");
    rd(8'h1c);
    chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    chk("unmapped_data", 32'h0, rq);
    pulse();
    repeat (5) @(posedge aclk);
    rchk(OFF_CSR, 32'h00, "trg_disabled");
    // abort a speed 0 conversion of input 2
    wr(OFF_CSR, 32'h62);
    repeat (50) @(posedge aclk);
    wr(OFF_CSR, 32'h42);
    repeat (300) @(posedge aclk);
    chk("abort_irq", 32'h0, {31'h0, irq});
    rchk(OFF_CSR, 32'h42, "abort_csr");
    rchk(OFF_RES_C, 32'h0, "abort_res");
    // single input 3, speed 0
    wr(OFF_CSR, 32'h63);
    t0 = cyc;
    wirq(t);
    chk("single_t0", 32'h1, {31'h0, (t - t0 >= 259 && t - t0 <= 266)});
    rchk(OFF_CSR, 32'hc3, "single_end");
    res(3, 3);
    wr(OFF_CSR, 32'h43);
    chk("flag_clear", 32'h0, {31'h0, irq});
    // single input 1, speed 1, clear without a read first
    wr(OFF_CSR, 32'h69);
    t0 = cyc;
    rchk(OFF_CSR, 32'h69, "run_held");
    wirq(t);
    chk("single_t1", 32'h1, {31'h0, (t - t0 >= 131 && t - t0 <= 134)});
    wr(OFF_CSR, 32'h49);
    chk("clear_unread", 32'h1, {31'h0, irq});
    rchk(OFF_CSR, 32'hc9, "flag_read");
    wr(OFF_CSR, 32'h49);
    chk("clear_read", 32'h0, {31'h0, irq});
    res(1, 1);
    // single input 1 with the interrupt disabled
    wr(OFF_CSR, 32'h29);
    repeat (150) @(posedge aclk);
    chk("irq_disabled", 32'h0, {31'h0, irq});
    rchk(OFF_CSR, 32'h89, "flag_no_irq");
    wr(OFF_CSR, 32'h09);
    // scan group 0, inputs 0 to 2, speed 1
    wr(OFF_CSR, 32'h7a);
    repeat (20) @(posedge aclk);
    chk("scan_first", 32'h0, {29'h0, ach});
    wirq(t);
    for (i = 0; i < 3; i++) res(i, i);
    rchk(OFF_CSR, 32'hfa, "scan_round");
    wr(OFF_CSR, 32'h7a);
    wirq(t1);
    chk("scan_period", 32'(3 * TSCAN1), 32'(t1 - t));
    rd(OFF_CSR);
    wr(OFF_CSR, 32'h5a);
    repeat (300) @(posedge aclk);
    chk("scan_stopped", 32'h0, {31'h0, irq});
    // trigger started scan of group 1, inputs 4 to 6
    wr(OFF_TRG, 32'h80);
    rchk(OFF_TRG, 32'hff, "trg_enable");
    wr(OFF_CSR, 32'h5e);
    pulse();
    repeat (20) @(posedge aclk);
    chk("trg_first", 32'h4, {29'h0, ach});
    rd(OFF_CSR);
    chk("trg_run", 32'h20, rq & 32'h20);
    wirq(t);
    for (i = 0; i < 3; i++) res(i, i + 4);
    n = 0;
    while (ach !== 3'h5)
    begin
      @(negedge aclk);
      n++;
      if (n > 1000) tmo();
    end
    rd(OFF_CSR);
    wr(OFF_CSR, 32'h5e);
    pulse();
    repeat (20) @(posedge aclk);
    chk("restart_first", 32'h4, {29'h0, ach});
    conclude();
  end
endmodule : adcs_sequencer_bench
